// >>> hdl/timer_readback_mode0_map.vh
`ifndef TIMER_READBACK_MODE0_MAP_VH
`define TIMER_READBACK_MODE0_MAP_VH

// Bus addresses, as {sel_hi, sel_lo}
`define ADDR_CNT0 2'h0
`define ADDR_CNT1 2'h1
`define ADDR_CNT2 2'h2
`define ADDR_CTRL 2'h3

// Control-register byte fields
`define CW_SC_HI 7
`define CW_SC_LO 6
`define CW_RW_HI 5
`define CW_RW_LO 4
`define CW_SC_READBACK 2'h3
`define CW_RW_LATCH 2'h0
`define RB_VALUE_LATCH_N 5
`define RB_STATE_SNAPSHOT_N 4
`define RB_SEL_HI 3
`define RB_SEL_LO 1

// Mode-control field as kept per counter: {rw[1:0], mode[2:0], bcd}
`define MC_RW_HI 5
`define MC_RW_LO 4
`define MC_MODE_HI 3
`define MC_MODE_LO 1
`define RW_LSB 2'h1
`define RW_MSB 2'h2
`define RW_BOTH 2'h3
`define MODE_TC_IRQ 3'h0
`define MODE_ONESHOT 3'h1
`define MODE_HW_STROBE 3'h5

// Reset values
`define MC_RESET 6'h00
`define COUNT_RESET 16'h0000

`endif

// >>> hdl/timer_readback_mode0.v
`timescale 1ns/1ps
`default_nettype none
`include "timer_readback_mode0_map.vh"

////////////////////////////////////////////////////////////////////////////
module counter_unit #(
    parameter WIDTH = 16
) (
    input wire clk_i,
    input wire reset_i,
    input wire ctrl_wr_i,
    input wire cnt_wr_i,
    input wire [7:0] data_i,
    input wire rd_done_i,
    input wire latch_cnt_i,
    input wire latch_st_i,
    input wire count_clk_i,
    input wire enable_pin_i,
    output reg [7:0] rd_data_o,
    output wire timer_pin_o
);
    reg [5:0] mc_r;
    reg [WIDTH-1:0] preset_r;
    reg [WIDTH-1:0] core_r;
    reg [WIDTH-1:0] hold_r;
    reg [7:0] state_r;
    reg out_r;
    reg pend_r;
    reg armed_r;
    reg wr_msb_r;
    reg rd_msb_r;
    reg hold_valid_r;
    reg state_valid_r;
    reg cclk_d_r;
    reg rise_seen_r;
    reg gate_d_r;
    reg trig_r;

    // Mode fields kept as written, for the status byte
    wire [1:0] rw = mc_r[`MC_RW_HI:`MC_RW_LO];
    wire [2:0] mode = mc_r[`MC_MODE_HI:`MC_MODE_LO];
    wire is_mode0 = (mode == `MODE_TC_IRQ);
    wire needs_trig = (mode == `MODE_ONESHOT) || (mode == `MODE_HW_STROBE);
    // Falling edge after a seen rise counts as one pulse
    wire pulse = cclk_d_r & ~count_clk_i & rise_seen_r;
    wire trigger = enable_pin_i & ~gate_d_r;
    // Triggered modes wait for an enable edge before loading
    wire do_load = pulse & pend_r & armed_r & (~needs_trig | trig_r);
    wire do_dec = pulse & armed_r & ~pend_r & enable_pin_i;
    wire [WIDTH-1:0] view = hold_valid_r ? hold_r : core_r;
    wire last_byte = (rw != `RW_BOTH) | rd_msb_r;
    wire [7:0] status_nxt = {out_r, pend_r, mc_r};
    // A latch in the same cycle as the consuming read still lands
    wire cnt_free = ~hold_valid_r |
        (rd_done_i & ~state_valid_r & last_byte);
    wire st_free = ~state_valid_r | rd_done_i;
    wire at_one = (core_r == {{(WIDTH-1){1'b0}}, 1'b1});

    assign timer_pin_o = out_r;

    // Status read leaves the count byte pointer where it is
    always @* begin
        if (state_valid_r) begin
            rd_data_o = state_r;
        end else if (rw == `RW_MSB || (rw == `RW_BOTH && rd_msb_r)) begin
            rd_data_o = view[15:8];
        end else begin
            rd_data_o = view[7:0];
        end
    end

    // Count clock is sampled, so it must run below half of clk_i
    always @(posedge clk_i) begin
        if (reset_i) begin
            cclk_d_r <= 1'b0;
            rise_seen_r <= 1'b0;
            gate_d_r <= 1'b0;
        end else begin
            cclk_d_r <= count_clk_i;
            gate_d_r <= enable_pin_i;
            if (count_clk_i & ~cclk_d_r) begin
                rise_seen_r <= 1'b1;
            end else if (pulse) begin
                rise_seen_r <= 1'b0;
            end
        end
    end

    always @(posedge clk_i) begin
        if (reset_i) begin
            mc_r <= `MC_RESET;
            preset_r <= `COUNT_RESET;
            core_r <= `COUNT_RESET;
            hold_r <= `COUNT_RESET;
            state_r <= 8'h00;
            out_r <= 1'b0;
            pend_r <= 1'b0;
            armed_r <= 1'b0;
            wr_msb_r <= 1'b0;
            rd_msb_r <= 1'b0;
            hold_valid_r <= 1'b0;
            state_valid_r <= 1'b0;
            trig_r <= 1'b0;
        end else begin
            // Counting element; writes below take priority in this cycle
            if (do_load) begin
                core_r <= preset_r;
                pend_r <= 1'b0;
                trig_r <= 1'b0;
            end else if (do_dec) begin
                // Count wraps past zero; timer_pin holds until rewritten
                core_r <= core_r - 1'b1;
                if (is_mode0 && at_one) begin
                    out_r <= 1'b1;
                end
            end
            // A trigger in the load cycle is kept for the next load
            if (trigger) begin
                trig_r <= 1'b1;
            end

            // Read side: status first, then the count bytes
            if (rd_done_i) begin
                if (state_valid_r) begin
                    state_valid_r <= 1'b0;
                end else begin
                    if (rw == `RW_BOTH) begin
                        rd_msb_r <= ~rd_msb_r;
                    end
                    if (last_byte) begin
                        hold_valid_r <= 1'b0;
                    end
                end
            end
            if (latch_cnt_i && cnt_free) begin
                hold_r <= core_r;
                hold_valid_r <= 1'b1;
            end
            if (latch_st_i && st_free) begin
                state_r <= status_nxt;
                state_valid_r <= 1'b1;
            end

            // Programming clears latches and byte pointers
            if (ctrl_wr_i) begin
                mc_r <= data_i[5:0];
                out_r <= 1'b0;
                pend_r <= 1'b1;
                armed_r <= 1'b0;
                wr_msb_r <= 1'b0;
                rd_msb_r <= 1'b0;
                hold_valid_r <= 1'b0;
                state_valid_r <= 1'b0;
                trig_r <= 1'b0;
            end else if (cnt_wr_i) begin
                pend_r <= 1'b1;
                if (is_mode0) begin
                    out_r <= 1'b0;
                end
                if (rw == `RW_LSB) begin
                    preset_r <= {8'h00, data_i};
                    armed_r <= 1'b1;
                end else if (rw == `RW_MSB) begin
                    preset_r <= {data_i, 8'h00};
                    armed_r <= 1'b1;
                end else if (!wr_msb_r) begin
                    // In mode 0 the first byte halts counting until the second lands
                    preset_r[7:0] <= data_i;
                    wr_msb_r <= 1'b1;
                    armed_r <= ~is_mode0;
                end else begin
                    preset_r[15:8] <= data_i;
                    wr_msb_r <= 1'b0;
                    armed_r <= 1'b1;
                end
            end
        end
    end
endmodule // counter_unit

////////////////////////////////////////////////////////////////////////////
module timer_readback_mode0 #(
    parameter WIDTH = 16
) (
    input wire clk_i,
    input wire reset_i,
    input wire chip_sel_n_i,
    input wire read_strobe_n_i,
    input wire store_strobe_n_i,
    input wire sel_hi_i,
    input wire sel_lo_i,
    input wire [7:0] data_i,
    output reg [7:0] data_o,
    output reg data_oe_n_o,
    input wire [2:0] count_clk_i,
    input wire [2:0] enable_pin_i,
    output wire [2:0] timer_pin_o
);
    // Bus decode; a read of the control address is a no-op
    wire [1:0] addr = {sel_hi_i, sel_lo_i};
    // The store strobe acts once, on the first cycle it is seen active
    wire wr_act = ~chip_sel_n_i & ~store_strobe_n_i & read_strobe_n_i;
    wire rd_act = ~chip_sel_n_i & ~read_strobe_n_i & store_strobe_n_i &
        (addr != `ADDR_CTRL);
    reg wr_d_r;
    reg rd_d_r;
    // Remembers which counter the current read addressed
    reg [1:0] rd_idx_r;
    wire wr_take = wr_act & ~wr_d_r;
    wire ctl_take = wr_take & (addr == `ADDR_CTRL);
    wire [1:0] sc = data_i[`CW_SC_HI:`CW_SC_LO];
    wire [1:0] rwf = data_i[`CW_RW_HI:`CW_RW_LO];
    wire readback = ctl_take & (sc == `CW_SC_READBACK);
    wire [2:0] rb_sel = data_i[`RB_SEL_HI:`RB_SEL_LO];
    wire [23:0] rd_bus;

    always @(posedge clk_i) begin
        if (reset_i) begin
            wr_d_r <= 1'b0;
            rd_d_r <= 1'b0;
            rd_idx_r <= `ADDR_CNT0;
            data_o <= 8'h00;
            data_oe_n_o <= 1'b1;
        end else begin
            wr_d_r <= wr_act;
            rd_d_r <= rd_act;
            // Enable trails the strobe by a cycle, in step with the data
            data_oe_n_o <= ~rd_act;
            if (rd_act) begin
                rd_idx_r <= addr;
                if (addr == `ADDR_CNT0) begin
                    data_o <= rd_bus[7:0];
                end else if (addr == `ADDR_CNT1) begin
                    data_o <= rd_bus[15:8];
                end else begin
                    data_o <= rd_bus[23:16];
                end
            end
        end
    end

    // One slice per counter; slices share only the bus
    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_cnt
            // Read advances when the read strobe ends
            wire rd_done = rd_d_r & ~rd_act & (rd_idx_r == i);
            wire cw_hit = ctl_take & (sc == i);
            wire ctrl_wr = cw_hit & (rwf != `CW_RW_LATCH);
            wire latch_cmd = cw_hit & (rwf == `CW_RW_LATCH);
            wire rb_hit = readback & rb_sel[i];
            wire latch_cnt = latch_cmd |
                (rb_hit & ~data_i[`RB_VALUE_LATCH_N]);
            wire latch_st = rb_hit & ~data_i[`RB_STATE_SNAPSHOT_N];
            // Counter write strobe for this slice only
            wire cnt_wr = wr_take & (addr == i);
            counter_unit #(
                .WIDTH(WIDTH)
            ) u_cnt (
                .clk_i(clk_i),
                .reset_i(reset_i),
                .ctrl_wr_i(ctrl_wr),
                .cnt_wr_i(cnt_wr),
                .data_i(data_i),
                .rd_done_i(rd_done),
                .latch_cnt_i(latch_cnt),
                .latch_st_i(latch_st),
                .count_clk_i(count_clk_i[i]),
                .enable_pin_i(enable_pin_i[i]),
                .rd_data_o(rd_bus[i*8 +: 8]),
                .timer_pin_o(timer_pin_o[i])
            );
        end
    endgenerate
endmodule // timer_readback_mode0

`default_nettype wire

// >>> dv/timer_readback_mode0_sva.sv
`timescale 1ns/1ps
`default_nettype none
module timer_readback_mode0_sva (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic chip_sel_n_i,
    input wire logic read_strobe_n_i,
    input wire logic store_strobe_n_i,
    input wire logic sel_hi_i,
    input wire logic sel_lo_i,
    input wire logic [7:0] data_i,
    input wire logic data_oe_n_o,
    input wire logic [2:0] count_clk_i,
    input wire logic [2:0] enable_pin_i,
    input wire logic [2:0] timer_pin_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    wire logic rd_ok;
    wire logic ctl;
    assign rd_ok = !chip_sel_n_i && !read_strobe_n_i && store_strobe_n_i;
    assign ctl = sel_hi_i && sel_lo_i;
    sequence rd_seen;
        (rd_ok && !ctl) [*3];
    endsequence
    sequence cw_c0;
        !chip_sel_n_i && !store_strobe_n_i && read_strobe_n_i && ctl
            && data_i[7:6] == 2'h0 && data_i[5:4] != 2'h0;
    endsequence
    a_reset_idle: assert property ($fell(reset_i) |-> data_oe_n_o
        && timer_pin_o == 3'h0) else $error("outputs not idle after reset");
    a_drive_on_read: assert property (rd_seen |-> !data_oe_n_o)
        else $error("bus not driven during read");
    a_ctrl_read: assert property (
        (rd_ok && ctl) [*3] |-> data_oe_n_o)
        else $error("bus driven on control read");
    a_cs_noop: assert property (chip_sel_n_i [*3] |-> data_oe_n_o)
        else $error("bus driven while deselected");
    a_drive_cause: assert property ($fell(data_oe_n_o) |->
        $past(rd_ok && !ctl, 1) || $past(rd_ok && !ctl, 2))
        else $error("bus driven without a read");
    a_ctrl_low: assert property (cw_c0 |-> ##[1:2] !timer_pin_o[0])
        else $error("control word left output high");
    a_rise_on_pulse: assert property ($rose(timer_pin_o[0]) |->
        ($past(count_clk_i[0], 1) || $past(count_clk_i[0], 2)))
        else $error("output rose without clock pulse");
    a_rise_gated: assert property ($rose(timer_pin_o[0]) |->
        $past(enable_pin_i[0], 1)) else $error("output rose while gated");
endmodule // timer_readback_mode0_sva
bind timer_readback_mode0 timer_readback_mode0_sva i_timer_readback_mode0_sva (
    .clk_i(clk_i), .reset_i(reset_i), .chip_sel_n_i(chip_sel_n_i),
    .read_strobe_n_i(read_strobe_n_i), .store_strobe_n_i(store_strobe_n_i),
    .sel_hi_i(sel_hi_i), .sel_lo_i(sel_lo_i), .data_i(data_i),
    .data_oe_n_o(data_oe_n_o), .count_clk_i(count_clk_i),
    .enable_pin_i(enable_pin_i), .timer_pin_o(timer_pin_o));
`default_nettype wire

// >>> dv/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic clk_i,
    input wire logic [7:0] dat_i,
    input wire logic oe_n_i,
    output logic cs_n_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic [1:0] addr_o,
    output logic [7:0] dat_o
);
    initial begin
        {cs_n_o, rd_n_o, wr_n_o, addr_o, dat_o} = 13'h1C00;
    end
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(negedge clk_i);
        {cs_n_o, wr_n_o, addr_o, dat_o} = {2'h0, a, d};
        @(negedge clk_i);
        {cs_n_o, wr_n_o} = 2'h3;
        // Released bus never shows the last byte
        dat_o = ~d;
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] d,
                      output logic oe);
        @(negedge clk_i);
        {cs_n_o, rd_n_o, addr_o} = {2'h0, a};
        repeat (3) @(negedge clk_i);
        d = dat_i;
        oe = oe_n_i;
        {cs_n_o, rd_n_o} = 2'h3;
        @(negedge clk_i);
    endtask
endmodule // host_model
`default_nettype wire

// >>> dv/timer_readback_mode0_tb.sv
`timescale 1ns/1ps
`default_nettype none
module timer_readback_mode0_tb;
    logic clk_i, reset_i, cs_n, rd_n, wr_n, oe_n;
    logic [1:0] addr;
    logic [7:0] din, dout;
    logic [2:0] count_clk_i, enable_pin_i, timer_pin_o;
    int n_errors = 0;
    int num_checks = 0;
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    timer_readback_mode0 i_timer_readback_mode0 (.clk_i(clk_i),
        .reset_i(reset_i), .chip_sel_n_i(cs_n), .read_strobe_n_i(rd_n),
        .store_strobe_n_i(wr_n), .sel_hi_i(addr[1]), .sel_lo_i(addr[0]),
        .data_i(din), .data_o(dout), .data_oe_n_o(oe_n),
        .count_clk_i(count_clk_i), .enable_pin_i(enable_pin_i),
        .timer_pin_o(timer_pin_o));
    host_model i_host_model (.clk_i(clk_i), .dat_i(dout), .oe_n_i(oe_n),
        .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .addr_o(addr),
        .dat_o(din));
    ////////////////////////////////////////////////////////////////////
    task automatic final_report;
        if (n_errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Control address only checks that the bus stays released
    task automatic rdc(input logic [1:0] a, input logic [7:0] e);
        logic [7:0] v;
        logic o;
        i_host_model.rd(a, v, o);
        chk({7'h00, o}, {7'h00, a == 2'h3});
        if (a != 2'h3)
            chk(v, e);
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        i_host_model.wr(a, d);
    endtask
    task automatic pulse(input logic [2:0] m, input int k);
        repeat (k) begin
            @(negedge clk_i);
            count_clk_i = m;
            repeat (2) @(negedge clk_i);
            count_clk_i = 3'h0;
            repeat (2) @(negedge clk_i);
        end
    endtask
    task automatic pin(input logic [2:0] e);
        chk({5'h00, timer_pin_o}, {5'h00, e});
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        reset_i = 1'b1;
        count_clk_i = 3'h0;
        enable_pin_i = 3'h7;
        repeat (20) @(negedge clk_i);
        reset_i = 1'b0;
        pin(3'h0);
        rdc(2'h3, 8'h00);
        wr(2'h3, 8'h30);
        pin(3'h0);
        wr(2'h0, 8'h05);
        wr(2'h0, 8'h00);
        wr(2'h3, 8'hE2);
        rdc(2'h0, 8'h70);
        pulse(3'h1, 1);
        wr(2'h3, 8'hC2);
        rdc(2'h0, 8'h30);
        rdc(2'h0, 8'h05);
        rdc(2'h0, 8'h00);
        enable_pin_i = 3'h6;
        pulse(3'h1, 2);
        wr(2'h3, 8'hD2);
        rdc(2'h0, 8'h05);
        rdc(2'h0, 8'h00);
        enable_pin_i = 3'h7;
        pulse(3'h1, 2);
        wr(2'h3, 8'hD2);
        pulse(3'h1, 1);
        wr(2'h3, 8'hD2);
        rdc(2'h0, 8'h03);
        rdc(2'h0, 8'h00);
        wr(2'h0, 8'h04);
        wr(2'h3, 8'hE2);
        wr(2'h3, 8'hD2);
        pulse(3'h1, 1);
        wr(2'h0, 8'h00);
        pulse(3'h1, 1);
        wr(2'h3, 8'hC2);
        rdc(2'h0, 8'h70);
        rdc(2'h0, 8'h02);
        rdc(2'h0, 8'h00);
        pulse(3'h1, 3);
        pin(3'h0);
        pulse(3'h1, 1);
        pin(3'h1);
        wr(2'h3, 8'hE2);
        rdc(2'h0, 8'hB0);
        wr(2'h0, 8'h09);
        pin(3'h0);
        wr(2'h0, 8'h00);
        wr(2'h3, 8'h50);
        wr(2'h1, 8'h07);
        pulse(3'h2, 1);
        wr(2'h3, 8'hE2);
        rdc(2'h1, 8'h07);
        wr(2'h3, 8'hE4);
        rdc(2'h1, 8'h10);
        wr(2'h3, 8'h92);
        wr(2'h2, 8'h03);
        pulse(3'h4, 1);
        wr(2'h3, 8'hE8);
        rdc(2'h2, 8'h52);
        enable_pin_i = 3'h3;
        @(negedge clk_i);
        enable_pin_i = 3'h7;
        pulse(3'h4, 1);
        wr(2'h3, 8'hE8);
        rdc(2'h2, 8'h12);
        rdc(2'h2, 8'h03);
        final_report();
    end
endmodule // timer_readback_mode0_tb
`default_nettype wire
